//--- hdl/pcf_defs.vh
// constants for the copper/fiber management register slice
`ifndef PCF_DEFS_VH
`define PCF_DEFS_VH
// register indices; byte address is four times the index
`define PCF_IDX_FIBER_CONTROL 5'h00
`define PCF_IDX_COPPER_CONTROL_TWO 5'h14
`define PCF_IDX_RECEIVE_ERROR_COUNTER 5'h15
`define PCF_IDX_PAGE_SELECT 5'h16
`define PCF_IDX_PORT_INTERRUPT_SUMMARY 5'h17
`define PCF_IDX_LAST_PAGED 5'h1C
// pages
`define PCF_PAGE_COPPER 8'h00
`define PCF_PAGE_FIBER 8'h01
// copper_control_two fields
`define PCF_CC2_RESET 16'h0020
`define PCF_CC2_IPG_KEEP_BIT 6
// fiber_control fields
`define PCF_FC_RESET_BIT 15
`define PCF_FC_LOOPBACK_BIT 14
`define PCF_FC_SPEED_LSB_BIT 13
`define PCF_FC_SPEED_MSB_BIT 6
`define PCF_FC_SPEED_LSB_RESET 1'b0
`define PCF_FC_SPEED_MSB_RESET 1'b1
// media mode codes
`define PCF_MODE_100FX 2'h0
`define PCF_MODE_1000X 2'h1
`define PCF_MODE_SGMII 2'h2
`define PCF_MODE_SW 2'h3
// speed codes, msb then lsb
`define PCF_SPEED_1000 2'h2
`define PCF_SPEED_100 2'h1
`define PCF_SPEED_10 2'h0
// receive error counter
`define PCF_ERR_MAX 16'hFFFF
// fiber soft reset duration
`define PCF_CLK_PERIOD_NS 4
`define PCF_FIBER_RST_NS 100
`define PCF_FIBER_RST_CYC ((`PCF_FIBER_RST_NS + `PCF_CLK_PERIOD_NS - 1) / `PCF_CLK_PERIOD_NS)
`endif

//--- hdl/pcf_err_cnt.v
// saturating receive error counter, cleared by a read capture
`timescale 1ns/1ps
`include "pcf_defs.vh"
module pcf_err_cnt (
  // clock and reset
  input wire mclk_in,
  input wire reset_in,
  // events and clear
  input wire false_carrier_in,
  input wire symbol_error_in,
  input wire clear_in,
  // count
  output reg [15:0] count_q_out
);
  wire [16:0] events_w;
  wire [16:0] sum_w;
  reg [15:0] count_d;

  // both kinds of receive error are counted, two in one cycle add two
  assign events_w = {16'h0000, false_carrier_in} + {16'h0000, symbol_error_in};
  assign sum_w = {1'b0, count_q_out} + events_w;

  always @*
  begin
    // events in the clearing cycle are kept, not lost
    if (clear_in)
      count_d = events_w[15:0];
    else if (sum_w[16])
      count_d = `PCF_ERR_MAX;
    else
      count_d = sum_w[15:0];
  end

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      count_q_out <= 16'h0000;
    else
      count_q_out <= count_d;
  end
endmodule // pcf_err_cnt

//--- hdl/pcf_rst_seq.v
// fixed-length fiber soft reset sequencer
`timescale 1ns/1ps
`include "pcf_defs.vh"
module pcf_rst_seq (
  // clock and reset
  input wire mclk_in,
  input wire reset_in,
  // control
  input wire start_in,
  output reg busy_q_out
);
  localparam integer RST_CYC_I = `PCF_FIBER_RST_CYC;
  localparam [7:0] RST_CYC = RST_CYC_I[7:0];
  reg [7:0] cnt_q;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      busy_q_out <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (start_in)
    begin
      // a new start restarts the full reset period
      busy_q_out <= 1'b1;
      cnt_q <= RST_CYC - 8'h01;
    end
    else if (busy_q_out)
    begin
      if (cnt_q == 8'h00)
        busy_q_out <= 1'b0;
      else
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // pcf_rst_seq

//--- hdl/pcf_regs.v
// paged copper/fiber management registers behind an avalon-mm slave
`timescale 1ns/1ps
`include "pcf_defs.vh"
// Overview of operation
// - bit 6 clear breaks link on short IPG
// - four bits invert transmit polarity per pair
// - error counter pegs at all ones
// - false carrier and symbol errors both count
// - page field selects page, upper byte zero
// - bit 0 shows port interrupt, rest zero
// - fiber reset bit self-clears after reset
// - fiber reset touches only page one
// - loopback returns transmit data, breaks media link
// - loopback speed follows the media mode
// - mode 00 lsb reads 1, 01 reads 0
// - mode 10 lsb reads 100 Mb/s status
// - mode 11 speed bits writable, encode speed
module pcf_regs (
  // clock and reset
  input wire mclk_in,
  input wire reset_in,
  // avalon-mm slave
  input wire [6:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // copper receive error events
  input wire false_carrier_in,
  input wire symbol_error_in,
  // copper control
  output wire ipg_link_break_out,
  output wire [3:0] media_pair_pins_tx_invert_out,
  // port interrupt and status
  input wire port_irq_in,
  input wire [1:0] media_mode_in,
  input wire [1:0] phy_speed_in,
  output wire [7:0] page_out,
  // fiber control
  output wire fiber_sm_reset_out,
  output wire loopback_en_out,
  output wire media_link_break_out,
  output wire [1:0] loopback_speed_out,
  // internal data bus
  input wire [7:0] int_txd_in,
  input wire int_tx_en_in,
  input wire [7:0] media_rxd_in,
  input wire media_rx_dv_in,
  output reg [7:0] int_rxd_out,
  output reg int_rx_dv_out
);
  // bus handshake state
  reg ack_q;
  wire req_w;
  wire rd_cap_w;
  wire wr_acc_w;
  wire [4:0] idx_w;
  wire [15:0] wmask_w;
  wire [15:0] wdata_w;

  // register state
  reg [15:0] cc2_q;
  reg [7:0] page_q;
  reg loopback_q;
  reg speed_lsb_q;
  reg speed_msb_q;
  wire [15:0] err_count_w;
  wire rst_busy_w;

  // decode and read mux
  reg sel_fc;
  reg sel_cc2;
  reg sel_err;
  reg sel_page;
  reg sel_irq;
  reg [15:0] rdata_d;
  reg speed_lsb_rd;
  reg speed_msb_rd;
  reg [1:0] lb_speed_sel;
  wire fc_wr_w;
  wire start_rst_w;

  // one wait cycle on every access: read data is captured in the first
  // cycle so it can come straight from a flip-flop at the accepting edge
  assign req_w = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req_w & ~ack_q;
  assign rd_cap_w = avs_read_in & ~ack_q;
  assign wr_acc_w = avs_write_in & ack_q;
  assign idx_w = avs_address_in[6:2];
  assign wdata_w = avs_writedata_in[15:0];

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_lane
      assign wmask_w[gi] = avs_byteenable_in[gi / 8];
    end
  endgenerate

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      ack_q <= 1'b0;
    else
      ack_q <= req_w & ~ack_q;
  end

  // address decode: page select is visible on every page
  always @*
  begin
    sel_fc = 1'b0;
    sel_cc2 = 1'b0;
    sel_err = 1'b0;
    sel_page = 1'b0;
    sel_irq = 1'b0;
    if (idx_w == `PCF_IDX_PAGE_SELECT)
      sel_page = 1'b1;
    // indices past the paged range are unmapped on every page
    else if (idx_w > `PCF_IDX_LAST_PAGED)
      sel_page = 1'b0;
    else if (page_q == `PCF_PAGE_FIBER)
      sel_fc = (idx_w == `PCF_IDX_FIBER_CONTROL);
    else if (page_q == `PCF_PAGE_COPPER)
    begin
      if (idx_w == `PCF_IDX_COPPER_CONTROL_TWO)
        sel_cc2 = 1'b1;
      else if (idx_w == `PCF_IDX_RECEIVE_ERROR_COUNTER)
        sel_err = 1'b1;
      else if (idx_w == `PCF_IDX_PORT_INTERRUPT_SUMMARY)
        sel_irq = 1'b1;
    end
  end

  // speed select bits as seen by software, per media mode
  always @*
  begin
    case (media_mode_in)
      `PCF_MODE_100FX:
      begin
        speed_lsb_rd = 1'b1;
        speed_msb_rd = 1'b0;
      end
      `PCF_MODE_1000X:
      begin
        speed_lsb_rd = 1'b0;
        speed_msb_rd = 1'b1;
      end
      `PCF_MODE_SGMII:
      begin
        speed_lsb_rd = (phy_speed_in == `PCF_SPEED_100);
        speed_msb_rd = (phy_speed_in == `PCF_SPEED_1000);
      end
      default:
      begin
        speed_lsb_rd = speed_lsb_q;
        speed_msb_rd = speed_msb_q;
      end
    endcase
  end

  // read data; unmapped addresses and reserved bits read zero, except copper control two, which reads back as stored
  always @*
  begin
    rdata_d = 16'h0000;
    if (sel_fc)
    begin
      rdata_d[`PCF_FC_RESET_BIT] = rst_busy_w;
      rdata_d[`PCF_FC_LOOPBACK_BIT] = loopback_q;
      rdata_d[`PCF_FC_SPEED_LSB_BIT] = speed_lsb_rd;
      rdata_d[`PCF_FC_SPEED_MSB_BIT] = speed_msb_rd;
    end
    else if (sel_cc2)
      rdata_d = cc2_q;
    else if (sel_err)
      rdata_d = err_count_w;
    else if (sel_page)
      rdata_d = {8'h00, page_q};
    else if (sel_irq)
      rdata_d = {15'h0000, port_irq_in};
  end

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      avs_readdata_out <= 32'h00000000;
    else if (rd_cap_w)
      avs_readdata_out <= {16'h0000, rdata_d};
  end

  // copper control two: reserved bits are stored as written, the
  // register relies on software writing their reset values back
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      cc2_q <= `PCF_CC2_RESET;
    else if (wr_acc_w && sel_cc2)
      cc2_q <= (cc2_q & ~wmask_w) | (wdata_w & wmask_w);
  end

  assign ipg_link_break_out = ~cc2_q[`PCF_CC2_IPG_KEEP_BIT];
  assign media_pair_pins_tx_invert_out = cc2_q[3:0];

  // page select
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      page_q <= 8'h00;
    // upper byte is read-only zero, so only lane 0 is stored
    else if (wr_acc_w && sel_page && avs_byteenable_in[0])
      page_q <= wdata_w[7:0];
  end

  assign page_out = page_q;

  // receive error counter, cleared by the read that captures it
  pcf_err_cnt u_err_cnt (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .false_carrier_in(false_carrier_in),
    .symbol_error_in(symbol_error_in),
    .clear_in(rd_cap_w && sel_err),
    .count_q_out(err_count_w)
  );

  // fiber control
  assign fc_wr_w = wr_acc_w && sel_fc;
  // a second start while busy restarts the period; other fiber writes are dropped
  assign start_rst_w = fc_wr_w && avs_byteenable_in[1] && wdata_w[`PCF_FC_RESET_BIT];

  pcf_rst_seq u_rst_seq (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .start_in(start_rst_w),
    .busy_q_out(rst_busy_w)
  );

  assign fiber_sm_reset_out = rst_busy_w;

  // soft reset clears only the page one loopback; speed bits retain
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      loopback_q <= 1'b0;
      speed_lsb_q <= `PCF_FC_SPEED_LSB_RESET;
      speed_msb_q <= `PCF_FC_SPEED_MSB_RESET;
    end
    else if (start_rst_w || rst_busy_w)
      loopback_q <= 1'b0;
    else if (fc_wr_w)
    begin
      if (avs_byteenable_in[1])
        loopback_q <= wdata_w[`PCF_FC_LOOPBACK_BIT];
      if (avs_byteenable_in[1] && media_mode_in == `PCF_MODE_SW)
        speed_lsb_q <= wdata_w[`PCF_FC_SPEED_LSB_BIT];
      if (avs_byteenable_in[0] && media_mode_in == `PCF_MODE_SW)
        speed_msb_q <= wdata_w[`PCF_FC_SPEED_MSB_BIT];
    end
  end

  assign loopback_en_out = loopback_q;
  assign media_link_break_out = loopback_q;

  // loopback rate is fixed by fiber modes, otherwise the speed bits
  always @*
  begin
    case (media_mode_in)
      `PCF_MODE_100FX:
        lb_speed_sel = `PCF_SPEED_100;
      `PCF_MODE_1000X:
        lb_speed_sel = `PCF_SPEED_1000;
      default:
        lb_speed_sel = {speed_msb_rd, speed_lsb_rd};
    endcase
  end

  assign loopback_speed_out = lb_speed_sel;

  // internal receive bus: one register stage in both paths
  // so switching loopback never changes the receive latency
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      int_rxd_out <= 8'h00;
      int_rx_dv_out <= 1'b0;
    end
    else if (loopback_q)
    begin
      int_rxd_out <= int_txd_in;
      int_rx_dv_out <= int_tx_en_in;
    end
    else
    begin
      int_rxd_out <= media_rxd_in;
      int_rx_dv_out <= media_rx_dv_in;
    end
  end
endmodule // pcf_regs

//--- verification/pcf_regs_props.sv
// assertions on the port behaviour of the register slice
`timescale 1ns/1ps
module pcf_regs_props (
  // clock, reset and bus
  input wire mclk_in,
  input wire reset_in,
  input wire [6:0] avs_address_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire avs_waitrequest_out,
  // controls and data
  input wire ipg_link_break_out,
  input wire [3:0] media_pair_pins_tx_invert_out,
  input wire [1:0] media_mode_in,
  input wire [7:0] page_out,
  input wire fiber_sm_reset_out,
  input wire loopback_en_out,
  input wire media_link_break_out,
  input wire [1:0] loopback_speed_out,
  input wire [7:0] int_txd_in,
  input wire [7:0] int_rxd_out
);
  reg [7:0] rst_len_q;
  wire acc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire [4:0] idx = avs_address_in[6:2];
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      rst_len_q <= 8'h00;
    else
      rst_len_q <= fiber_sm_reset_out ? rst_len_q + 8'h01 : 8'h00;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  AST_IPG_KEEP: assert property (acc && idx == 5'h14 && page_out == 8'h00
    |=> ipg_link_break_out == !$past(avs_writedata_in[6])) else $error("ipg break wrong");
  AST_TX_INVERT: assert property (acc && idx == 5'h14 && page_out == 8'h00
    |=> media_pair_pins_tx_invert_out == $past(avs_writedata_in[3:0])) else $error("invert wrong");
  AST_PAGE_SET: assert property (acc && idx == 5'h16
    |=> page_out == $past(avs_writedata_in[7:0])) else $error("page wrong");
  AST_LB_LINK: assert property (media_link_break_out == loopback_en_out)
    else $error("link break not tied to loopback");
  AST_LB_DATA: assert property (loopback_en_out |=> int_rxd_out == $past(int_txd_in))
    else $error("loopback data wrong");
  AST_LB_SPEED: assert property (loopback_en_out && !media_mode_in[1]
    |-> loopback_speed_out == (media_mode_in[0] ? 2'h2 : 2'h1)) else $error("lb speed wrong");
  AST_RST_LEN: assert property ($fell(fiber_sm_reset_out) |-> rst_len_q == 8'h19)
    else $error("fiber reset length wrong");
  AST_RST_LB: assert property (fiber_sm_reset_out |-> !loopback_en_out)
    else $error("loopback kept in fiber reset");
endmodule // pcf_regs_props

//--- verification/pcf_host.sv
// management host model: avalon-mm master
`timescale 1ns/1ps
module pcf_host (
  // clock
  input wire mclk_in,
  // avalon-mm master
  output reg [6:0] avs_address_out,
  output reg avs_read_out,
  output reg avs_write_out,
  output reg [31:0] avs_writedata_out,
  output reg [3:0] avs_byteenable_out,
  input wire [31:0] avs_readdata_in,
  input wire avs_waitrequest_in
);
  initial
  begin
    avs_address_out = 7'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h00000000;
    avs_byteenable_out = 4'h0;
  end
  // waitrequest and read data are taken at the rising edge, before its updates land
  task xfer(input wr, input [6:0] a, input [15:0] d, output [15:0] q);
    reg w;
    begin
      @(posedge mclk_in);
      avs_address_out <= a;
      avs_read_out <= !wr;
      avs_write_out <= wr;
      avs_writedata_out <= {16'h0000, d};
      avs_byteenable_out <= 4'h3;
      w = 1'b1;
      q = 16'h0000;
      while (w)
      begin
        @(posedge mclk_in);
        w = avs_waitrequest_in;
        q = avs_readdata_in[15:0];
      end
      avs_read_out <= 1'b0;
      avs_write_out <= 1'b0;
      avs_writedata_out <= ~avs_writedata_out;
      // let the accepting edge's register updates settle before callers look
      @(negedge mclk_in);
    end
  endtask
endmodule // pcf_host

//--- verification/testbench.sv
// self-checking bench for the register slice
`timescale 1ns/1ps
bind pcf_regs pcf_regs_props i_pcf_regs_props (.mclk_in(mclk_in), .reset_in(reset_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out), .ipg_link_break_out(ipg_link_break_out),
  .media_pair_pins_tx_invert_out(media_pair_pins_tx_invert_out),
  .media_mode_in(media_mode_in), .page_out(page_out),
  .fiber_sm_reset_out(fiber_sm_reset_out), .loopback_en_out(loopback_en_out),
  .media_link_break_out(media_link_break_out), .loopback_speed_out(loopback_speed_out),
  .int_txd_in(int_txd_in), .int_rxd_out(int_rxd_out));
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg fc = 1'b0;
  reg se = 1'b0;
  reg irq = 1'b0;
  reg [1:0] mode = 2'h0;
  reg [1:0] spd = 2'h0;
  reg [7:0] txd = 8'h00;
  reg txen = 1'b1;
  reg [15:0] q;
  integer fails = 0;
  integer comparisons = 0;
  integer cycles = 0;
  wire [6:0] adr;
  wire rd, wr, wt, ipg, fsr, lb, lbrk, rxdv;
  wire [31:0] wd, rdat;
  wire [3:0] be, inv;
  wire [7:0] pg, rxd;
  wire [1:0] lbs;
  pcf_host i_pcf_host (.mclk_in(clk), .avs_address_out(adr), .avs_read_out(rd),
    .avs_write_out(wr), .avs_writedata_out(wd), .avs_byteenable_out(be),
    .avs_readdata_in(rdat), .avs_waitrequest_in(wt));
  pcf_regs i_pcf_regs (.mclk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .false_carrier_in(fc), .symbol_error_in(se),
    .ipg_link_break_out(ipg), .media_pair_pins_tx_invert_out(inv), .port_irq_in(irq),
    .media_mode_in(mode), .phy_speed_in(spd), .page_out(pg), .fiber_sm_reset_out(fsr),
    .loopback_en_out(lb), .media_link_break_out(lbrk), .loopback_speed_out(lbs),
    .int_txd_in(txd), .int_tx_en_in(txen), .media_rxd_in(8'h3C), .media_rx_dv_in(1'b1),
    .int_rxd_out(rxd), .int_rx_dv_out(rxdv));
  always #2 clk = ~clk;
  task conclude;
  begin
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      fails = fails + 1;
      conclude;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("unexpected %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wrt(input [6:0] a, input [15:0] d);
    i_pcf_host.xfer(1'b1, a, d, q);
  endtask
  task rdc(input [6:0] a, input [15:0] e);
  begin
    i_pcf_host.xfer(1'b0, a, 16'h0000, q);
    chk("readdata", e, q);
  end
  endtask
  task pulse(input f, input s, input integer n);
    repeat (n)
    begin
      @(posedge clk);
      fc <= f;
      se <= s;
    end
  endtask
  task set(input [1:0] m, input [1:0] s);
  begin
    @(posedge clk);
    mode <= m;
    spd <= s;
  end
  endtask
  task t_reset;
  begin
    rdc(7'h50, 16'h0020);
    rdc(7'h58, 16'h0000);
    rdc(7'h5C, 16'h0000);
    chk("ipg_break", 16'h0001, {15'h0000, ipg});
    chk("rxd", 16'h003C, {8'h00, rxd});
    chk("rx_dv", 16'h0001, {15'h0000, rxdv});
  end
  endtask
  task t_copper;
    integer n;
    reg [15:0] v;
    for (n = 0; n < 4; n = n + 1)
    begin
      v = 16'h0020 | (16'h0001 << n) | (n[0] ? 16'h0040 : 16'h0000);
      wrt(7'h50, v);
      chk("ipg_break", {15'h0000, !v[6]}, {15'h0000, ipg});
      chk("invert", {12'h000, v[3:0]}, {12'h000, inv});
      rdc(7'h50, v);
    end
  endtask
  task t_err;
  begin
    pulse(1'b1, 1'b0, 1);
    pulse(1'b1, 1'b1, 2);
    pulse(1'b0, 1'b0, 1);
    rdc(7'h54, 16'h0005);
    rdc(7'h54, 16'h0000);
    pulse(1'b1, 1'b1, 32770);
    pulse(1'b0, 1'b0, 1);
    rdc(7'h54, 16'hFFFF);
  end
  endtask
  task t_page;
  begin
    wrt(7'h58, 16'h0055);
    chk("page", 16'h0055, {8'h00, pg});
    rdc(7'h58, 16'h0055);
    rdc(7'h50, 16'h0000);
    rdc(7'h74, 16'h0000);
    wrt(7'h58, 16'h0000);
    @(posedge clk);
    irq <= 1'b1;
    rdc(7'h5C, 16'h0001);
    @(posedge clk);
    irq <= 1'b0;
  end
  endtask
  task t_fiber;
  begin
    wrt(7'h58, 16'h0001);
    set(2'h0, 2'h0);
    rdc(7'h00, 16'h2000);
    set(2'h1, 2'h0);
    rdc(7'h00, 16'h0040);
    set(2'h2, 2'h1);
    rdc(7'h00, 16'h2000);
    set(2'h2, 2'h2);
    rdc(7'h00, 16'h0040);
    set(2'h3, 2'h0);
    wrt(7'h00, 16'h2000);
    rdc(7'h00, 16'h2000);
    chk("lb_speed", 16'h0001, {14'h0000, lbs});
    set(2'h1, 2'h0);
    wrt(7'h00, 16'h4040);
    chk("loopback", 16'h0001, {15'h0000, lbrk});
    chk("loopback_en", 16'h0001, {15'h0000, lb});
    chk("lb_speed", 16'h0002, {14'h0000, lbs});
    @(posedge clk);
    txd <= 8'hA5;
    txen <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("rxd", 16'h00A5, {8'h00, rxd});
    chk("rx_dv", 16'h0000, {15'h0000, rxdv});
    set(2'h0, 2'h0);
    @(negedge clk);
    chk("lb_speed", 16'h0001, {14'h0000, lbs});
    wrt(7'h00, 16'h8000);
    chk("fiber_reset", 16'h0001, {15'h0000, fsr});
    rdc(7'h00, 16'hA000);
    repeat (30) @(posedge clk);
    rdc(7'h00, 16'h2000);
    set(2'h3, 2'h0);
    rdc(7'h00, 16'h2000);
    wrt(7'h58, 16'h0000);
    rdc(7'h50, 16'h0068);
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_copper;
    t_err;
    t_page;
    t_fiber;
    conclude;
  end
endmodule // testbench
